// *** cag_pkg.sv ***
package cag_pkg;

    localparam logic [31:0] CAG_TBR_RESET      = 32'h000FFC00;
    localparam logic [31:0] CAG_RESET_VEC_ADDR = 32'h000FFFFC;
    localparam logic [31:0] CAG_VEC_TOP_OFS    = 32'h000003FC;
    localparam logic [31:0] CAG_IP_STEP        = 32'h00000002;
    localparam logic [31:0] CAG_WORD_MASK      = 32'hFFFFFFFC;
    localparam logic [31:0] CAG_HALF_MASK      = 32'hFFFFFFFE;
    localparam logic [31:0] CAG_BYTE_MASK      = 32'hFFFFFFFF;

    localparam logic [7:0] CAG_VEC_RESET      = 8'h00;
    localparam logic [7:0] CAG_VEC_COPRO_ABS  = 8'h07;
    localparam logic [7:0] CAG_VEC_COPRO_ERR  = 8'h08;
    localparam logic [7:0] CAG_VEC_EMU_B      = 8'h09;
    localparam logic [7:0] CAG_VEC_INSN_BRK   = 8'h0A;
    localparam logic [7:0] CAG_VEC_OPND_BRK   = 8'h0B;
    localparam logic [7:0] CAG_VEC_STEP_TRACE = 8'h0C;
    localparam logic [7:0] CAG_VEC_EMU_A      = 8'h0D;
    localparam logic [7:0] CAG_VEC_UNDEF      = 8'h0E;
    localparam logic [7:0] CAG_VEC_NMI        = 8'h0F;
    localparam logic [7:0] CAG_VEC_IRQ_LO     = 8'h10;
    localparam logic [7:0] CAG_VEC_IRQ_HI     = 8'h2F;

    typedef enum logic [1:0] {
        CAG_SZ_BYTE = 2'h0,
        CAG_SZ_HALF = 2'h1,
        CAG_SZ_WORD = 2'h2
    } cag_size_e;

    typedef enum logic [2:0] {
        CAG_OP_FETCH  = 3'h0,
        CAG_OP_DIRECT = 3'h1,
        CAG_OP_DATA   = 3'h2,
        CAG_OP_VECTOR = 3'h3,
        CAG_OP_TBR_WR = 3'h4
    } cag_op_e;

    typedef enum logic [2:0] {
        CAG_ST_RST_VEC = 3'b001,
        CAG_ST_IDLE    = 3'b010,
        CAG_ST_BUSY    = 3'b100
    } cag_state_e;

    typedef enum logic [3:0] {
        CAG_VC_SOFT      = 4'h0,
        CAG_VC_IRQ       = 4'h1,
        CAG_VC_NMI       = 4'h2,
        CAG_VC_UNDEF     = 4'h3,
        CAG_VC_EMU       = 4'h4,
        CAG_VC_STEP      = 4'h5,
        CAG_VC_OPND_BRK  = 4'h6,
        CAG_VC_INSN_BRK  = 4'h7,
        CAG_VC_COPRO_ERR = 4'h8,
        CAG_VC_COPRO_ABS = 4'h9,
        CAG_VC_RESET     = 4'hA
    } cag_vclass_e;

    typedef struct packed {
        cag_op_e     op;
        cag_size_e   size;
        logic        we;
        logic [7:0]  dir8;
        logic [31:0] base;
        logic [31:0] offset;
        logic [31:0] wdata;
        logic [7:0]  vec_num;
    } cag_req_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  be;
        logic        we;
        logic [31:0] wdata;
    } cag_bus_s;

    typedef struct packed {
        cag_vclass_e cls;
        logic [4:0]  irq_idx;
    } cag_vec_s;

endpackage

// *** cag_lane_map.sv ***
module cag_lane_map
    import cag_pkg::*;
(
    input  wire logic [1:0]  i_addr_lo,
    input  wire cag_size_e   i_size,
    input  wire logic [31:0] i_wdata,
    input  wire logic [31:0] i_rdata,
    output logic      [3:0]  o_be,
    output logic      [31:0] o_wlane,
    output logic      [31:0] o_rdata_ext
);

    // Lowest address owns bits 31:24 (big-endian lanes)
    wire logic [3:0] be_byte = 4'h8 >> i_addr_lo;
    wire logic [3:0] be_half = i_addr_lo[1] ? 4'h3 : 4'hC;
    wire logic [4:0] sh_byte = {2'h3 - i_addr_lo, 3'h0};
    wire logic [4:0] sh_half = i_addr_lo[1] ? 5'h00 : 5'h10;

    assign o_be = (i_size == CAG_SZ_BYTE) ? be_byte :
                  (i_size == CAG_SZ_HALF) ? be_half : 4'hF;

    assign o_wlane = (i_size == CAG_SZ_BYTE) ? (i_wdata << sh_byte) :
                     (i_size == CAG_SZ_HALF) ? (i_wdata << sh_half) :
                     i_wdata;

    wire logic [31:0] r_byte = i_rdata >> sh_byte;
    wire logic [31:0] r_half = i_rdata >> sh_half;

    assign o_rdata_ext = (i_size == CAG_SZ_BYTE) ? {24'h000000, r_byte[7:0]} :
                         (i_size == CAG_SZ_HALF) ? {16'h0000, r_half[15:0]} :
                         i_rdata;

endmodule

// *** cag_addr_gen.sv ***
// Notes on behaviour
// - Memory is one linear byte-addressed space with 32-bit addresses.
// - Direct accesses take their address from the instruction operand only.
// - Byte direct access: operand is address bits 7:0, rest zero.
// - Half-word direct access: operand shifted left one, bits 8:0.
// - Word direct access: operand shifted left two, bits 9:0.
// - Direct reach ends at 0xFF, 0x1FF and 0x3FF by size.
// - Vector table is a 1 KB region starting at the table base.
// - Entry for number n is word at base plus 0x3FC minus 4n.
// - Numbers 0x2F..0x10 are soft or peripheral irq; 0x0F also NMI.
// - Fixed numbers 0x0E..0x07 name the listed exceptions and traps.
// - Reset vector is always read from 0x000FFFFC.
// - Reset loads the table base with 0x000FFC00.
// - Software writes relocate the table, word aligned.
// - Bit 0 is the least significant bit.
// - Multi-byte data is big-endian: MSB at lowest address.
// - Fetch addresses are even; odd pointer bit 0 is ignored.
// - Word data accesses force address bits 1:0 to zero.
// - Half-word data accesses force address bit 0 to zero.
// - Byte data accesses use the computed address unchanged.
// - Alignment is applied after address arithmetic, not to sources.
// - After reset the pointer loads from the reset vector entry.
module cag_addr_gen
    import cag_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_req_valid,
    output logic             o_req_ready,
    input  wire cag_req_s    i_req,
    input  wire logic        i_ip_load,
    input  wire logic [31:0] i_ip_value,
    output logic      [31:0] o_instruction_pointer,
    output logic             o_ip_ready,
    output logic      [31:0] o_vector_table_base,
    output logic             o_mem_req,
    output cag_bus_s         o_mem,
    input  wire logic        i_mem_ack,
    input  wire logic [31:0] i_mem_rdata,
    output logic             o_rsp_valid,
    output logic      [31:0] o_rsp_data,
    output logic      [31:0] o_rsp_addr,
    output cag_vec_s         o_vec_info
);

    cag_state_e  state_q;
    cag_state_e  state_d;
    logic [31:0] tbr_q;
    logic [31:0] ip_q;
    logic        ip_ready_q;
    cag_bus_s    bus_q;
    cag_size_e   size_q;
    cag_op_e     op_q;
    logic        rsp_valid_q;
    logic [31:0] rsp_data_q;
    logic [31:0] rsp_addr_q;
    cag_vec_s    vec_q;

    // Request decode
    wire logic accept = (state_q == CAG_ST_IDLE) && i_req_valid;
    wire logic is_tbr = (i_req.op == CAG_OP_TBR_WR);
    wire logic issue  = accept && !is_tbr;

    // Direct address: only the operand, never a register
    wire logic [31:0] dir_byte = {24'h000000, i_req.dir8};
    wire logic [31:0] dir_half = {23'h000000, i_req.dir8, 1'b0};
    wire logic [31:0] dir_word = {22'h000000, i_req.dir8, 2'b00};
    // Upper bits stay zero, so reach ends at 0xFF/0x1FF/0x3FF
    wire logic [31:0] dir_addr =
        (i_req.size == CAG_SZ_BYTE) ? dir_byte :
        (i_req.size == CAG_SZ_HALF) ? dir_half : dir_word;

    // Register-relative sum, full 32-bit wrap in a linear space
    wire logic [31:0] data_sum = i_req.base + i_req.offset;

    // Low bits forced on the final sum only, sources untouched
    wire logic [31:0] size_mask =
        (i_req.size == CAG_SZ_WORD) ? CAG_WORD_MASK :
        (i_req.size == CAG_SZ_HALF) ? CAG_HALF_MASK :
        CAG_BYTE_MASK;
    wire logic [31:0] data_addr = data_sum & size_mask;

    // Fetch ignores pointer bit 0 even if a branch wrote it odd
    wire logic [31:0] fetch_addr = ip_q & CAG_HALF_MASK;

    // Vector entry: base + 0x3FC - 4n, where 0x3FC - 4n is {~n, 00}
    wire logic [31:0] tbr_word  = tbr_q & CAG_WORD_MASK;
    wire logic [31:0] vec_ofs   = {22'h000000, ~i_req.vec_num, 2'b00};
    wire logic [31:0] vec_table = tbr_word + vec_ofs;
    // Reset entry is pinned whatever the base holds
    wire logic        vec_is_rst = (i_req.vec_num == CAG_VEC_RESET);
    wire logic [31:0] vec_addr =
        vec_is_rst ? CAG_RESET_VEC_ADDR : vec_table;

    wire logic [31:0] next_addr =
        (i_req.op == CAG_OP_FETCH)  ? fetch_addr :
        (i_req.op == CAG_OP_DIRECT) ? dir_addr :
        (i_req.op == CAG_OP_VECTOR) ? vec_addr : data_addr;

    wire cag_size_e next_size =
        (i_req.op == CAG_OP_FETCH)  ? CAG_SZ_HALF :
        (i_req.op == CAG_OP_VECTOR) ? CAG_SZ_WORD : i_req.size;

    // Writes only for data-type operations
    wire logic next_we = i_req.we &&
        ((i_req.op == CAG_OP_DIRECT) || (i_req.op == CAG_OP_DATA));

    // Vector classification
    wire logic [7:0] vn       = i_req.vec_num;
    wire logic       vc_irq   = (vn >= CAG_VEC_IRQ_LO) && (vn <= CAG_VEC_IRQ_HI);
    wire logic [7:0] irq_diff = vn - CAG_VEC_IRQ_LO;
    wire logic       vc_emu   = (vn == CAG_VEC_EMU_A) || (vn == CAG_VEC_EMU_B);

    wire cag_vclass_e vclass =
        vc_irq                     ? CAG_VC_IRQ :
        (vn == CAG_VEC_NMI)        ? CAG_VC_NMI :
        (vn == CAG_VEC_UNDEF)      ? CAG_VC_UNDEF :
        vc_emu                     ? CAG_VC_EMU :
        (vn == CAG_VEC_STEP_TRACE) ? CAG_VC_STEP :
        (vn == CAG_VEC_OPND_BRK)   ? CAG_VC_OPND_BRK :
        (vn == CAG_VEC_INSN_BRK)   ? CAG_VC_INSN_BRK :
        (vn == CAG_VEC_COPRO_ERR)  ? CAG_VC_COPRO_ERR :
        (vn == CAG_VEC_COPRO_ABS)  ? CAG_VC_COPRO_ABS :
        vec_is_rst                 ? CAG_VC_RESET : CAG_VC_SOFT;

    wire cag_vec_s vec_next = '{cls: vclass,
                                irq_idx: vc_irq ? irq_diff[4:0] : 5'h00};

    // Lane placement for the request being issued and the one in flight
    logic [3:0]  lane_be;
    logic [31:0] lane_wdata;
    logic [31:0] lane_unused;
    logic [31:0] rd_ext;

    cag_lane_map u_lane_issue (
        .i_addr_lo   (next_addr[1:0]),
        .i_size      (next_size),
        .i_wdata     (i_req.wdata),
        .i_rdata     (32'h00000000),
        .o_be        (lane_be),
        .o_wlane     (lane_wdata),
        .o_rdata_ext (lane_unused)
    );

    logic [3:0]  rd_be_unused;
    logic [31:0] rd_wl_unused;

    cag_lane_map u_lane_return (
        .i_addr_lo   (bus_q.addr[1:0]),
        .i_size      (size_q),
        .i_wdata     (32'h00000000),
        .i_rdata     (i_mem_rdata),
        .o_be        (rd_be_unused),
        .o_wlane     (rd_wl_unused),
        .o_rdata_ext (rd_ext)
    );

    wire cag_bus_s bus_next = '{addr: next_addr, be: lane_be,
                                we: next_we, wdata: lane_wdata};

    wire logic done = (state_q != CAG_ST_IDLE) && i_mem_ack;

    always_comb begin
        state_d = state_q;
        case (state_q)
            CAG_ST_RST_VEC: begin
                if (i_mem_ack) begin
                    state_d = CAG_ST_IDLE;
                end
            end
            CAG_ST_IDLE: begin
                if (issue) begin
                    state_d = CAG_ST_BUSY;
                end
            end
            CAG_ST_BUSY: begin
                if (i_mem_ack) begin
                    state_d = CAG_ST_IDLE;
                end
            end
            default: begin
                state_d = CAG_ST_IDLE;
            end
        endcase
    end

    // Reset vector read is armed by reset itself, before anything else
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= CAG_ST_RST_VEC;
            bus_q   <= '{addr: CAG_RESET_VEC_ADDR, be: 4'hF,
                         we: 1'b0, wdata: 32'h00000000};
            size_q  <= CAG_SZ_WORD;
            op_q    <= CAG_OP_VECTOR;
        end else begin
            state_q <= state_d;
            if (issue) begin
                bus_q  <= bus_next;
                size_q <= next_size;
                op_q   <= i_req.op;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tbr_q <= CAG_TBR_RESET;
        end else if (accept && is_tbr) begin
            tbr_q <= i_req.wdata;
        end
    end

    // Pointer: vector return beats a branch, a branch beats increment
    wire logic ip_from_vec = done && (op_q == CAG_OP_VECTOR);
    wire logic ip_step     = issue && (i_req.op == CAG_OP_FETCH);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ip_q       <= 32'h00000000;
            ip_ready_q <= 1'b0;
        end else begin
            if (ip_from_vec) begin
                ip_q <= i_mem_rdata;
            end else if (i_ip_load) begin
                ip_q <= i_ip_value;
            end else if (ip_step) begin
                ip_q <= fetch_addr + CAG_IP_STEP;
            end
            if (ip_from_vec) begin
                ip_ready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 32'h00000000;
            rsp_addr_q  <= 32'h00000000;
        end else begin
            rsp_valid_q <= done;
            if (done) begin
                rsp_data_q <= bus_q.we ? 32'h00000000 : rd_ext;
                rsp_addr_q <= bus_q.addr;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            vec_q <= '{cls: CAG_VC_RESET, irq_idx: 5'h00};
        end else if (issue && (i_req.op == CAG_OP_VECTOR)) begin
            vec_q <= vec_next;
        end
    end

    // Stalls until the reset entry has been loaded
    assign o_req_ready           = (state_q == CAG_ST_IDLE);
    assign o_mem_req             = (state_q != CAG_ST_IDLE);
    assign o_mem                 = bus_q;
    assign o_instruction_pointer = ip_q;
    assign o_ip_ready            = ip_ready_q;
    assign o_vector_table_base   = tbr_q;
    assign o_rsp_valid           = rsp_valid_q;
    assign o_rsp_data            = rsp_data_q;
    assign o_rsp_addr            = rsp_addr_q;
    assign o_vec_info            = vec_q;

endmodule

// *** cag_addr_gen_assertions.sv ***
module cag_addr_gen_assertions
    import cag_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_req_valid,
    input  wire logic        o_req_ready,
    input  wire cag_req_s    i_req,
    input  wire logic        i_ip_load,
    input  wire logic [31:0] i_ip_value,
    input  wire logic [31:0] o_instruction_pointer,
    input  wire logic        o_ip_ready,
    input  wire logic [31:0] o_vector_table_base,
    input  wire logic        o_mem_req,
    input  wire cag_bus_s    o_mem,
    input  wire logic        i_mem_ack,
    input  wire logic [31:0] i_mem_rdata,
    input  wire logic        o_rsp_valid,
    input  wire logic [31:0] o_rsp_data,
    input  wire logic [31:0] o_rsp_addr,
    input  wire cag_vec_s    o_vec_info
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_ready_idle: assert property (o_req_ready |-> !o_mem_req)
        else $error("ready while access outstanding");
    a_bus_hold: assert property (o_mem_req && !i_mem_ack |=>
        o_mem_req && $stable(o_mem))
        else $error("bus request changed before ack");
    a_rsp_after: assert property (o_mem_req && i_mem_ack |=>
        o_rsp_valid && o_req_ready ##1 !o_rsp_valid)
        else $error("response not one cycle after ack");
    a_word_align: assert property (o_mem_req &&
        o_mem.be == 4'hF |-> o_mem.addr[1:0] == 2'h0)
        else $error("word access not aligned");
    a_half_align: assert property (o_mem_req &&
        (o_mem.be == 4'hC || o_mem.be == 4'h3) |->
        o_mem.addr[0] == 1'b0 && o_mem.be == (o_mem.addr[1] ? 4'h3 : 4'hC))
        else $error("half access lane or alignment wrong");
    a_byte_lane: assert property (o_mem_req &&
        $onehot(o_mem.be) |-> o_mem.be == (4'h8 >> o_mem.addr[1:0]))
        else $error("byte lane does not match address");
    a_ip_load: assert property (i_ip_load && !o_mem_req |=>
        o_instruction_pointer == $past(i_ip_value))
        else $error("pointer load lost");
    a_base_write: assert property (i_req_valid && o_req_ready &&
        i_req.op == CAG_OP_TBR_WR |=>
        o_vector_table_base == $past(i_req.wdata))
        else $error("table base not written");
endmodule

// *** cag_mem_model.sv ***
module cag_mem_model
    import cag_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_slow,
    input  wire logic        i_mem_req,
    input  wire cag_bus_s    i_mem,
    output logic             o_mem_ack,
    output logic      [31:0] o_mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_q;
    wire  logic [2:0] lat = i_slow ? 3'h4 : 3'h0;
    // Data lines toggle outside an ack so stale values never match
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_q      <= 3'h0;
            o_mem_ack   <= 1'b0;
            o_mem_rdata <= 32'h0;
        end else if (i_mem_req && !o_mem_ack && wait_q == lat) begin
            o_mem_ack   <= 1'b1;
            wait_q      <= 3'h0;
            o_mem_rdata <= (i_mem.addr & 32'hFFFFFFFC)
                           ^ 32'hA5C30F96;
        end else begin
            o_mem_ack   <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata;
            if (i_mem_req && !o_mem_ack) begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule

// *** cag_addr_gen_tb.sv ***
module cag_addr_gen_tb
    import cag_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, valid = 0, ip_load = 0, ack, slow = 0;
    logic [31:0] ip_value = 32'h0, rdata, ip, vector_table_base, rsp_data, rsp_addr;
    logic        req_ready, ip_ready, mem_req, rsp_valid;
    cag_req_s    req = '0;
    cag_bus_s    mem, seen_bus;
    cag_vec_s    vec_info;
    logic [31:0] sdata, saddr, a, m;
    int          n_errors = 0, checks_done = 0;

    cag_addr_gen dut (.i_clk(clk), .i_sys_rst(rst), .i_req_valid(valid),
        .o_req_ready(req_ready), .i_req(req), .i_ip_load(ip_load),
        .i_ip_value(ip_value), .o_instruction_pointer(ip),
        .o_ip_ready(ip_ready), .o_vector_table_base(vector_table_base),
        .o_mem_req(mem_req), .o_mem(mem), .i_mem_ack(ack),
        .i_mem_rdata(rdata), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .o_rsp_addr(rsp_addr), .o_vec_info(vec_info));
    cag_mem_model u_mem (.i_clk(clk), .i_sys_rst(rst), .i_slow(slow),
        .i_mem_req(mem_req), .i_mem(mem), .o_mem_ack(ack),
        .o_mem_rdata(rdata));

    initial begin
        forever #4 clk = ~clk;
    end

    task end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task tmo(string what);
        n_errors++;
        $display("BAD %s exp done seen timeout", what);
        end_of_test();
    endtask

    // Expected read data, worked out lane by lane from the word
    function automatic logic [31:0] rd(logic [31:0] ad, cag_size_e sz);
        logic [31:0] w;
        w = (ad & 32'hFFFFFFFC) ^ 32'hA5C30F96;
        if (sz == CAG_SZ_BYTE) return (w >> (8 * (3 - ad[1:0]))) & 32'hFF;
        if (sz == CAG_SZ_HALF) return (w >> (16 * (1 - ad[1]))) & 32'hFFFF;
        return w;
    endfunction

    task issue(cag_op_e op, cag_size_e sz, logic we, logic [7:0] d,
               logic [31:0] b, logic [31:0] o, logic [31:0] wd,
               logic [7:0] n);
        int k;
        req = '{op, sz, we, d, b, o, wd, n};
        valid = 1'b1;
        k = 0;
        while (req_ready !== 1'b1) begin
            @(posedge clk); #1;
            k++;
            if (k > 50) tmo("ready");
        end
        @(posedge clk); #1;
        valid = 1'b0;
        seen_bus = mem;
        k = 0;
        while (op != CAG_OP_TBR_WR && rsp_valid !== 1'b1) begin
            @(posedge clk); #1;
            k++;
            if (k > 50) tmo("response");
        end
        sdata = rsp_data;
        saddr = rsp_addr;
        if (op == CAG_OP_TBR_WR) begin
            @(posedge clk);
            #1;
        end
    endtask

    task t_reset;
        repeat (2) @(posedge clk);
        #1;
        chk("reset bus addr", mem.addr, 32'h000FFFFC);
        chk("reset base", vector_table_base, 32'h000FFC00);
        chk("reset ready", {req_ready, ip_ready}, 32'h0);
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        issue(CAG_OP_TBR_WR, CAG_SZ_WORD, 1'b1, 8'h0, 32'h000FFC00, 32'h0,
              32'h000FFC00, 8'h0);
        chk("reset entry", ip, rd(32'h000FFFFC, CAG_SZ_WORD));
        chk("pointer ready", ip_ready, 32'h1);
    endtask

    task t_direct;
        for (int s = 0; s < 3; s++) begin
            for (int i = 0; i < 2; i++) begin
                a = {24'h0, i ? 8'h57 : 8'hFF} << s;
                issue(CAG_OP_DIRECT, cag_size_e'(s), 1'b0, a >> s,
                      32'h12345679, 32'h11, 32'h0, 8'h0);
                chk("direct addr", saddr, a);
                chk("direct reach", saddr >> (8 + s), 32'h0);
                chk("direct data", sdata, rd(a, cag_size_e'(s)));
            end
        end
    endtask

    task t_data;
        for (int s = 0; s < 3; s++) begin
            for (int o = 1; o < 5; o++) begin
                m = s == 2 ? 32'hFFFFFFFC : s == 1 ? 32'hFFFFFFFE : '1;
                a = (32'h00001003 + o) & m;
                issue(CAG_OP_DATA, cag_size_e'(s), 1'b0, 8'h0, 32'h00001003,
                      o, 32'h0, 8'h0);
                chk("data addr", saddr, a);
                chk("data read", sdata, rd(a, cag_size_e'(s)));
            end
        end
        issue(CAG_OP_DATA, CAG_SZ_BYTE, 1'b1, 8'h0, 32'h2000, 32'h1,
              32'h000000AB, 8'h0);
        chk("byte lane", seen_bus.wdata[23:16], 32'hAB);
        chk("byte enable", {seen_bus.we, seen_bus.be}, 32'h14);
        chk("write rsp", sdata, 32'h0);
        issue(CAG_OP_DATA, CAG_SZ_HALF, 1'b1, 8'h0, 32'h2001, 32'h1,
              32'h00001234, 8'h0);
        chk("half lane", seen_bus.wdata[15:0], 32'h1234);
        chk("half enable", seen_bus.be, 32'h3);
    endtask

    task t_vector;
        logic [7:0]  vn [13];
        cag_vclass_e vc [13];
        vn = '{8'hFF, 8'h2F, 8'h10, 8'h0F, 8'h0E, 8'h0D, 8'h0C, 8'h0B,
               8'h0A, 8'h09, 8'h08, 8'h07, 8'h00};
        vc = '{CAG_VC_SOFT, CAG_VC_IRQ, CAG_VC_IRQ, CAG_VC_NMI, CAG_VC_UNDEF,
               CAG_VC_EMU, CAG_VC_STEP, CAG_VC_OPND_BRK, CAG_VC_INSN_BRK,
               CAG_VC_EMU, CAG_VC_COPRO_ERR, CAG_VC_COPRO_ABS, CAG_VC_RESET};
        slow = 1'b1;
        issue(CAG_OP_TBR_WR, CAG_SZ_WORD, 1'b1, 8'h0, 32'h00012347, 32'h0,
              32'h00012347, 8'h0);
        chk("base raw", vector_table_base, 32'h00012347);
        for (int i = 0; i < 13; i++) begin
            a = vn[i] == 8'h0 ? 32'h000FFFFC : 32'h00012344 + 32'h3FC
                - 4 * vn[i];
            // Peripheral source index counts up from number 0x10
            m = vc[i] == CAG_VC_IRQ ? vn[i] - 8'h10 : 32'h0;
            issue(CAG_OP_VECTOR, CAG_SZ_WORD, 1'b1, 8'h0, 32'h0, 32'h0,
                  32'h0, vn[i]);
            chk("vector addr", saddr, a);
            chk("vector entry", ip, rd(a, CAG_SZ_WORD));
            chk("vector class", vec_info.cls, vc[i]);
            chk("vector irq", vec_info.irq_idx, m);
        end
        slow = 1'b0;
    endtask

    task t_fetch;
        ip_value = 32'h00003457;
        ip_load = 1'b1;
        @(posedge clk); #1;
        ip_load = 1'b0;
        chk("odd pointer", ip, 32'h00003457);
        issue(CAG_OP_FETCH, CAG_SZ_HALF, 1'b1, 8'h0, 32'h0, 32'h0, 32'h0,
              8'h0);
        chk("fetch addr", saddr, 32'h00003456);
        chk("fetch write", seen_bus.we, 32'h0);
        chk("next pointer", ip, 32'h00003458);
    endtask

    initial begin
        t_reset();
        t_direct();
        t_data();
        t_vector();
        t_fetch();
        end_of_test();
    end
endmodule

bind cag_addr_gen cag_addr_gen_assertions u_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .i_ip_load(i_ip_load),
    .i_ip_value(i_ip_value), .o_instruction_pointer(o_instruction_pointer),
    .o_ip_ready(o_ip_ready), .o_vector_table_base(o_vector_table_base),
    .o_mem_req(o_mem_req), .o_mem(o_mem), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .o_rsp_valid(o_rsp_valid),
    .o_rsp_data(o_rsp_data), .o_rsp_addr(o_rsp_addr),
    .o_vec_info(o_vec_info));
